// [logic/bar_relays.sv]
// Auxiliary relay outputs of a breaker trip unit with AXI4-Lite registers.
// Assumes synchronous inputs from the protection engine and one clock.
//
// Behaviour
// - An enabled trip event latches the segregated-trip relay.
// - Each of the seven trip types and the slow-mechanism event has its own latch enable bit.
// - Only a release taken after a display press clears the latch.
// - The segregated-trip contact is closed only while latched.
// - The alarm relay is energized above 105% of long-time pickup.
// - The alarm relay drops below that level or on a trip.
// - Load relays act only with the load-monitoring profile selected.
// - Each load relay has its own pickup and its own delay.
// - A load relay drops on a trip or 10 s after falling below pickup.
// - Mechanism time above 33 ms after an own trip is a slow event.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "bar_cfg.svh"

module bar_relays #(
    parameter logic [15:0] CYC_PER_MS = 16'(`BAR_CYC_PER_MS),
    parameter logic [15:0] HOLD_MS = 16'(`BAR_HOLD_MS)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] trip_event,
    input wire logic breaker_trip,
    input wire logic trip_pulse_sent,
    input wire logic breaker_open,
    input wire logic lt_over_alarm,
    input wire logic [1:0] lm_above,
    input wire logic display_press,
    input wire logic unlatch_choice,
    output logic segregated_trip_relay,
    output logic pretrip_alarm_relay,
    output logic load_monitor_relay_a,
    output logic load_monitor_relay_b,
    output logic release_offered
);

    logic [8:0] ctrl_r;
    logic [8:0] ctrl_nxt;
    logic [15:0] dly_r [2];
    logic [15:0] dly_nxt [2];
    logic slow_flag_r;
    logic slow_flag_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wr_go;
    logic slow_clr;
    logic [15:0] ms_cnt_r, ms_cnt_nxt;
    logic ms_tick_r, ms_tick_nxt;
    logic [5:0] mech_cnt_r, mech_cnt_nxt;
    logic mech_run_r, mech_run_nxt;
    logic slow_event;
    bar_pkg::bar_latch_type latch_r, latch_nxt;
    logic seg_r, seg_nxt, alarm_r, alarm_nxt;
    logic offer_r, offer_nxt;
    logic [7:0] events;
    logic [1:0] lm_relay;

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !awready_r &&
        !bvalid_r;

    // Handshakes, responses and register writes
    always_comb begin
        awready_nxt = wr_go;
        wready_nxt = wr_go;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        arready_nxt = s_axi_arvalid && !arready_r && !rvalid_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        ctrl_nxt = ctrl_r;
        dly_nxt[0] = dly_r[0];
        dly_nxt[1] = dly_r[1];
        slow_clr = 1'b0;
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt = `BAR_RESP_OKAY;
            if (s_axi_awaddr == `BAR_OFS_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    ctrl_nxt[7:0] = s_axi_wdata[7:0];
                end
                if (s_axi_wstrb[1]) begin
                    ctrl_nxt[8] = s_axi_wdata[8];
                end
            end else if (s_axi_awaddr == `BAR_OFS_DLY_A) begin
                if (s_axi_wstrb[0]) dly_nxt[0][7:0] = s_axi_wdata[7:0];
                if (s_axi_wstrb[1]) dly_nxt[0][15:8] = s_axi_wdata[15:8];
            end else if (s_axi_awaddr == `BAR_OFS_DLY_B) begin
                if (s_axi_wstrb[0]) dly_nxt[1][7:0] = s_axi_wdata[7:0];
                if (s_axi_wstrb[1]) dly_nxt[1][15:8] = s_axi_wdata[15:8];
            end else if (s_axi_awaddr == `BAR_OFS_STAT) begin
                slow_clr = s_axi_wstrb[0] &&
                    s_axi_wdata[`BAR_STAT_SLOW_BIT];
            end else begin
                bresp_nxt = `BAR_RESP_SLVERR;
            end
        end
        if (arready_nxt) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `BAR_RESP_OKAY;
            rdata_nxt = 32'h00000000;
            if (s_axi_araddr == `BAR_OFS_CTRL) begin
                rdata_nxt[8:0] = ctrl_r;
            end else if (s_axi_araddr == `BAR_OFS_DLY_A) begin
                rdata_nxt[15:0] = dly_r[0];
            end else if (s_axi_araddr == `BAR_OFS_DLY_B) begin
                rdata_nxt[15:0] = dly_r[1];
            end else if (s_axi_araddr == `BAR_OFS_STAT) begin
                rdata_nxt[5:0] = {slow_flag_r, release_offered,
                    lm_relay, alarm_r, seg_r};
            end else begin
                rresp_nxt = `BAR_RESP_SLVERR;
            end
        end
        // Sticky slow-mechanism flag: a new event beats a clear
        slow_flag_nxt = slow_event || (slow_flag_r && !slow_clr);
    end

    // Bus and register flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `BAR_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= `BAR_RESP_OKAY;
            rdata_r <= 32'h00000000;
            ctrl_r <= `BAR_CTRL_RST;
            dly_r[0] <= `BAR_DLY_RST;
            dly_r[1] <= `BAR_DLY_RST;
            slow_flag_r <= 1'b0;
        end else begin
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r <= ctrl_nxt;
            dly_r[0] <= dly_nxt[0];
            dly_r[1] <= dly_nxt[1];
            slow_flag_r <= slow_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick and mechanism timer
    // ------------------------------------------------------------
    always_comb begin
        ms_tick_nxt = (ms_cnt_r == CYC_PER_MS - 16'h0001);
        ms_cnt_nxt = ms_tick_nxt ? 16'h0000 : ms_cnt_r + 16'h0001;
        mech_run_nxt = mech_run_r;
        mech_cnt_nxt = mech_cnt_r;
        slow_event = 1'b0;
        if (trip_pulse_sent) begin
            mech_run_nxt = 1'b1;
            mech_cnt_nxt = 6'h00;
        end else if (mech_run_r) begin
            if (breaker_open) begin
                mech_run_nxt = 1'b0;
            end else if (ms_tick_r) begin
                mech_cnt_nxt = mech_cnt_r + 6'h01;
                if (mech_cnt_r == 6'(`BAR_SLOW_MECH_MS)) begin
                    slow_event = 1'b1;
                    mech_run_nxt = 1'b0;
                end
            end
        end
    end

    // Timer flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt_r <= 16'h0000;
            ms_tick_r <= 1'b0;
            mech_cnt_r <= 6'h00;
            mech_run_r <= 1'b0;
        end else begin
            ms_cnt_r <= ms_cnt_nxt;
            ms_tick_r <= ms_tick_nxt;
            mech_cnt_r <= mech_cnt_nxt;
            mech_run_r <= mech_run_nxt;
        end
    end

    // ------------------------------------------------------------
    // Segregated-trip latch and pre-trip alarm
    // ------------------------------------------------------------
    assign events = {slow_event, trip_event};

    always_comb begin
        latch_nxt = latch_r;
        case (latch_r)
            bar_pkg::BAR_LATCH_OPEN: begin
                if (|(events & ctrl_r[7:0])) begin
                    latch_nxt = bar_pkg::BAR_LATCH_SET;
                end
            end
            bar_pkg::BAR_LATCH_SET: begin
                if (display_press) begin
                    latch_nxt = bar_pkg::BAR_LATCH_OFFER;
                end
            end
            bar_pkg::BAR_LATCH_OFFER: begin
                if (|(events & ctrl_r[7:0])) begin
                    latch_nxt = bar_pkg::BAR_LATCH_SET;
                end else if (unlatch_choice) begin
                    latch_nxt = bar_pkg::BAR_LATCH_OPEN;
                end else if (display_press) begin
                    latch_nxt = bar_pkg::BAR_LATCH_SET;
                end
            end
            default: begin
                latch_nxt = bar_pkg::BAR_LATCH_OPEN;
            end
        endcase
        seg_nxt = (latch_nxt != bar_pkg::BAR_LATCH_OPEN);
        offer_nxt = (latch_nxt == bar_pkg::BAR_LATCH_OFFER);
        alarm_nxt = lt_over_alarm && !breaker_trip;
    end

    // Latch and alarm flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r <= bar_pkg::BAR_LATCH_OPEN;
            seg_r <= 1'b0;
            alarm_r <= 1'b0;
            offer_r <= 1'b0;
        end else begin
            latch_r <= latch_nxt;
            seg_r <= seg_nxt;
            alarm_r <= alarm_nxt;
            offer_r <= offer_nxt;
        end
    end

    // ------------------------------------------------------------
    // Load-monitoring relays
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_lm
        bar_load_mon #(
            .HOLD_MS(HOLD_MS)
        ) u_lm (
            .clk(clk),
            .rst_n(rst_n),
            .enable(ctrl_r[`BAR_CTRL_PROFILE_BIT]),
            .above(lm_above[i]),
            .trip(breaker_trip),
            .ms_tick(ms_tick_r),
            .delay_ms(dly_r[i]),
            .relay(lm_relay[i])
        );
    end

    // Outputs, all from flops
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign segregated_trip_relay = seg_r;
    assign pretrip_alarm_relay = alarm_r;
    assign load_monitor_relay_a = lm_relay[0];
    assign load_monitor_relay_b = lm_relay[1];
    assign release_offered = offer_r;

endmodule

// [logic/bar_cfg.svh]
// Constants for the breaker auxiliary relay logic.
// Assumes inclusion by bare name from files under logic/.
`ifndef BAR_CFG_SVH
`define BAR_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BAR_OFS_CTRL 4'h0
`define BAR_OFS_DLY_A 4'h4
`define BAR_OFS_DLY_B 4'h8
`define BAR_OFS_STAT 4'hC

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BAR_CTRL_PROFILE_BIT 8
`define BAR_STAT_SLOW_BIT 5
`define BAR_CTRL_RST 9'h000
`define BAR_DLY_RST 16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BAR_CLK_HZ 20000000
`define BAR_MS_PER_S 1000
`define BAR_CYC_PER_MS (`BAR_CLK_HZ / `BAR_MS_PER_S)
`define BAR_SLOW_MECH_MS 33
`define BAR_HOLD_S 10
`define BAR_HOLD_MS (`BAR_HOLD_S * `BAR_MS_PER_S)

// AXI responses
`define BAR_RESP_OKAY 2'h0
`define BAR_RESP_SLVERR 2'h2

`endif

// [logic/bar_pkg.sv]
// Types for the breaker auxiliary relay logic.
// Assumes nothing of its surroundings.
package bar_pkg;

    // Segregated-trip latch states
    typedef enum logic [1:0] {
        BAR_LATCH_OPEN = 2'b00,
        BAR_LATCH_SET = 2'b01,
        BAR_LATCH_OFFER = 2'b10
    } bar_latch_type;

    // Load-monitoring relay states
    typedef enum logic [1:0] {
        BAR_LM_OFF = 2'b00,
        BAR_LM_ON = 2'b01,
        BAR_LM_HOLD = 2'b10
    } bar_lm_type;

endpackage

// [logic/bar_load_mon.sv]
// One load-monitoring relay: pickup delay, energized state, off hold.
// Assumes a one-cycle millisecond tick and synchronous inputs.
`timescale 1ns/10ps
`include "bar_cfg.svh"

module bar_load_mon #(
    parameter logic [15:0] HOLD_MS = 16'(`BAR_HOLD_MS)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic above,
    input wire logic trip,
    input wire logic ms_tick,
    input wire logic [15:0] delay_ms,
    output logic relay
);

    bar_pkg::bar_lm_type state_r;
    bar_pkg::bar_lm_type state_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic relay_r;
    logic relay_nxt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            bar_pkg::BAR_LM_OFF: begin
                if (!enable || !above || trip) begin
                    cnt_nxt = 16'h0000;
                end else if (cnt_r >= delay_ms) begin
                    state_nxt = bar_pkg::BAR_LM_ON;
                end else if (ms_tick) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            bar_pkg::BAR_LM_ON: begin
                cnt_nxt = 16'h0000;
                if (!enable || trip) begin
                    state_nxt = bar_pkg::BAR_LM_OFF;
                end else if (!above) begin
                    state_nxt = bar_pkg::BAR_LM_HOLD;
                end
            end
            bar_pkg::BAR_LM_HOLD: begin
                if (!enable || trip) begin
                    state_nxt = bar_pkg::BAR_LM_OFF;
                    cnt_nxt = 16'h0000;
                end else if (above) begin
                    state_nxt = bar_pkg::BAR_LM_ON;
                    cnt_nxt = 16'h0000;
                end else if (cnt_r >= HOLD_MS) begin
                    state_nxt = bar_pkg::BAR_LM_OFF;
                    cnt_nxt = 16'h0000;
                end else if (ms_tick) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            default: begin
                state_nxt = bar_pkg::BAR_LM_OFF;
                cnt_nxt = 16'h0000;
            end
        endcase
        relay_nxt = (state_nxt != bar_pkg::BAR_LM_OFF);
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= bar_pkg::BAR_LM_OFF;
            cnt_r <= 16'h0000;
            relay_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            relay_r <= relay_nxt;
        end
    end

    assign relay = relay_r;

endmodule

// [verification/bar_breaker_model.sv]
// Breaker mechanism model driving the open limit switch.
// Assumes the bench sets the opening time in clock cycles.
`timescale 1ns/10ps
module bar_breaker_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trip_pulse_sent,
    input wire logic [15:0] open_cyc,
    output logic breaker_open
);
    logic [15:0] cnt_r;
    logic run_r;

    // Zero opening time wraps the count: the mechanism opens 65536 cycles after the pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            run_r <= 1'h0;
            breaker_open <= 1'h0;
        end else if (trip_pulse_sent) begin
            cnt_r <= 16'h0000;
            run_r <= 1'h1;
            breaker_open <= 1'h0;
        end else if (run_r) begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r + 16'h0001 == open_cyc) begin
                breaker_open <= 1'h1;
                run_r <= 1'h0;
            end
        end
    end
endmodule

// [verification/bar_relays_monitor.sv]
// Checker for the auxiliary relay block, watching its ports only.
// Assumes it is bound to every bar_relays instance.
`timescale 1ns/10ps
module bar_relays_monitor #(
    parameter logic [15:0] CYC_PER_MS = 16'h4E20,
    parameter logic [15:0] HOLD_MS = 16'h2710
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [6:0] trip_event,
    input wire logic breaker_trip,
    input wire logic lt_over_alarm,
    input wire logic [1:0] lm_above,
    input wire logic unlatch_choice,
    input wire logic segregated_trip_relay,
    input wire logic pretrip_alarm_relay,
    input wire logic load_monitor_relay_a,
    input wire logic load_monitor_relay_b,
    input wire logic release_offered
);
    localparam int CPM = int'(CYC_PER_MS);
    localparam int HOLD_MIN = (int'(HOLD_MS) - 1) * CPM;
    localparam int HOLD_MAX = (int'(HOLD_MS) + 1) * CPM + 4;
    int below_a_r;
    int below_a_nxt;

    // Cycles since relay A current last stood above pickup
    always_comb begin
        below_a_nxt = lm_above[0] ? 0 : below_a_r + 1;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            below_a_r <= 0;
        end else begin
            below_a_r <= below_a_nxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    seg_release_a: assert property (release_offered && unlatch_choice
        && trip_event == 7'h00 |=> !segregated_trip_relay)
        else $error("latched relay not released");
    seg_hold_a: assert property ($fell(segregated_trip_relay)
        |-> $past(release_offered) && $past(unlatch_choice))
        else $error("latched relay dropped without release");
    offer_latched_a: assert property (release_offered
        |-> segregated_trip_relay)
        else $error("release offered while open");
    alarm_on_a: assert property (lt_over_alarm && !breaker_trip
        |=> pretrip_alarm_relay)
        else $error("alarm relay not energized");
    alarm_off_a: assert property (!lt_over_alarm || breaker_trip
        |=> !pretrip_alarm_relay)
        else $error("alarm relay not dropped");
    lm_trip_a: assert property (breaker_trip
        |=> !load_monitor_relay_a && !load_monitor_relay_b)
        else $error("load relay kept after trip");
    lm_rise_a: assert property ($rose(load_monitor_relay_a)
        |-> $past(lm_above[0]))
        else $error("relay A energized below pickup");
    lm_b_rise_a: assert property ($rose(load_monitor_relay_b)
        |-> $past(lm_above[1]))
        else $error("relay B energized below pickup");
    hold_min_a: assert property ($fell(load_monitor_relay_a)
        && !$past(breaker_trip) |-> below_a_r >= HOLD_MIN)
        else $error("relay A hold too short");
    hold_max_a: assert property (load_monitor_relay_a
        |-> below_a_r <= HOLD_MAX)
        else $error("relay A hold too long");
    hold_keep_a: assert property (load_monitor_relay_a && lm_above[0]
        && !breaker_trip |=> load_monitor_relay_a)
        else $error("relay A dropped above pickup");
endmodule

bind bar_relays bar_relays_monitor #(
    .CYC_PER_MS(CYC_PER_MS),
    .HOLD_MS(HOLD_MS)
) u_mon (
    .clk(clk),
    .rst_n(rst_n),
    .trip_event(trip_event),
    .breaker_trip(breaker_trip),
    .lt_over_alarm(lt_over_alarm),
    .lm_above(lm_above),
    .unlatch_choice(unlatch_choice),
    .segregated_trip_relay(segregated_trip_relay),
    .pretrip_alarm_relay(pretrip_alarm_relay),
    .load_monitor_relay_a(load_monitor_relay_a),
    .load_monitor_relay_b(load_monitor_relay_b),
    .release_offered(release_offered)
);

// [verification/bar_relays_bench.sv]
// Self-checking bench for the auxiliary relay block.
// Assumes the bound monitor and a breaker model on the limit switch.
`timescale 1ns/10ps
`include "bar_cfg.svh"
module bar_relays_bench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata, rd_data;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rd_resp, wr_resp;
    logic [6:0] trip_event = 7'h00;
    logic breaker_trip = 1'h0, trip_pulse_sent = 1'h0, breaker_open;
    logic lt_over_alarm = 1'h0, display_press = 1'h0;
    logic unlatch_choice = 1'h0;
    logic [1:0] lm_above = 2'h0;
    logic [15:0] open_cyc = 16'h0000;
    logic seg, alarm, lm_a, lm_b, offered;
    int n_mismatch = 0;
    int checked = 0;

    // Clock of 50 ns
    always #25 clk = ~clk;

    bar_relays #(.CYC_PER_MS(16'h000A), .HOLD_MS(16'h0005)) u_dut (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .trip_event(trip_event),
        .breaker_trip(breaker_trip), .trip_pulse_sent(trip_pulse_sent),
        .breaker_open(breaker_open), .lt_over_alarm(lt_over_alarm),
        .lm_above(lm_above), .display_press(display_press),
        .unlatch_choice(unlatch_choice), .segregated_trip_relay(seg),
        .pretrip_alarm_relay(alarm), .load_monitor_relay_a(lm_a),
        .load_monitor_relay_b(lm_b), .release_offered(offered)
    );

    bar_breaker_model u_brk (
        .clk(clk), .rst_n(rst_n), .trip_pulse_sent(trip_pulse_sent),
        .open_cyc(open_cyc), .breaker_open(breaker_open)
    );

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // A bus wait that runs out ends the run
    task automatic guard(input int n);
        if (n >= 100) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            guard(n);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        wr_resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            guard(n);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'h0;
    endtask

    // Display button when choice is low, release choice when high
    task automatic ui(input logic choice);
        @(posedge clk);
        if (choice) unlatch_choice <= 1'h1;
        else display_press <= 1'h1;
        @(posedge clk);
        unlatch_choice <= 1'h0;
        display_press <= 1'h0;
        @(posedge clk);
    endtask

    task automatic ev(input int i);
        @(posedge clk);
        trip_event <= 7'h01 << i;
        @(posedge clk);
        trip_event <= 7'h00;
        step(3);
    endtask

    task automatic mech(input logic [15:0] c, input int n);
        @(posedge clk);
        open_cyc <= c;
        trip_pulse_sent <= 1'h1;
        @(posedge clk);
        trip_pulse_sent <= 1'h0;
        step(n);
    endtask

    // Main sequence
    initial begin
        step(8);
        rst_n <= 1'h1;
        step(2);
        check("seg rest", seg, 1'h0);
        rd(`BAR_OFS_CTRL);
        check("ctrl reset", rd_data, 32'h0);
        rd(4'h2);
        check("unmapped", rd_resp, `BAR_RESP_SLVERR);
        wr(4'h2, 32'hFFFF);
        check("wr unmapped", wr_resp, `BAR_RESP_SLVERR);
        for (int i = 0; i < 7; i++) begin
            wr(`BAR_OFS_CTRL, 32'h7F ^ (32'h1 << i));
            ev(i);
            check("seg masked", seg, 1'h0);
            wr(`BAR_OFS_CTRL, 32'h1 << i);
            ev(i);
            check("seg set", seg, 1'h1);
            ui(1'h0);
            check("offer", offered, 1'h1);
            check("seg held", seg, 1'h1);
            ui(1'h1);
            check("seg freed", seg, 1'h0);
        end
        wr(`BAR_OFS_CTRL, 32'h80);
        mech(16'h00C8, 500);
        check("fast mech", seg, 1'h0);
        rd(`BAR_OFS_STAT);
        check("no slow flag", rd_data[5], 1'h0);
        mech(16'h01F4, 450);
        check("slow latch", seg, 1'h1);
        rd(`BAR_OFS_STAT);
        check("slow flag", rd_data[5], 1'h1);
        wr(`BAR_OFS_STAT, 32'h20);
        rd(`BAR_OFS_STAT);
        check("slow cleared", rd_data[5], 1'h0);
        ui(1'h0);
        ui(1'h0);
        check("offer cancel", offered, 1'h0);
        check("seg kept", seg, 1'h1);
        ui(1'h0);
        ui(1'h1);
        lt_over_alarm <= 1'h1;
        step(2);
        check("alarm on", alarm, 1'h1);
        breaker_trip <= 1'h1;
        step(2);
        check("alarm trip", alarm, 1'h0);
        breaker_trip <= 1'h0;
        step(2);
        check("alarm back", alarm, 1'h1);
        lt_over_alarm <= 1'h0;
        step(2);
        check("alarm off", alarm, 1'h0);
        wr(`BAR_OFS_DLY_A, 32'h2);
        check("wr okay", wr_resp, `BAR_RESP_OKAY);
        wr(`BAR_OFS_DLY_B, 32'h6);
        rd(`BAR_OFS_DLY_A);
        check("delay A", rd_data, 32'h2);
        lm_above <= 2'h3;
        step(50);
        check("no profile", {lm_b, lm_a}, 2'h0);
        lm_above <= 2'h0;
        wr(`BAR_OFS_CTRL, 32'h100);
        lm_above <= 2'h3;
        step(40);
        check("A only", {lm_b, lm_a}, 2'h1);
        step(40);
        check("B too", lm_b, 1'h1);
        lm_above <= 2'h2;
        step(20);
        lm_above <= 2'h3;
        step(60);
        check("hold cancel", lm_a, 1'h1);
        lm_above <= 2'h0;
        step(30);
        check("in hold", {lm_b, lm_a}, 2'h3);
        step(40);
        check("hold over", {lm_b, lm_a}, 2'h0);
        lm_above <= 2'h3;
        step(80);
        check("both on", {lm_b, lm_a}, 2'h3);
        breaker_trip <= 1'h1;
        step(2);
        check("trip drop", {lm_b, lm_a}, 2'h0);
        breaker_trip <= 1'h0;
        lm_above <= 2'h0;
        step(2);
        tally_and_finish();
    end
endmodule
